//--- ident_page_pkg.sv
// Constants and carrier types for the identify parameter page generator
package ident_page_pkg;

	// ----------------------------------------------------------------
	// Software register offsets (word addresses on the plain port)
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_TOTAL_LO = 8'h01;
	localparam logic [7:0] REG_TOTAL_HI = 8'h02;
	localparam logic [7:0] REG_CYL = 8'h03;
	localparam logic [7:0] REG_HEADS = 8'h04;
	localparam logic [7:0] REG_SPT = 8'h05;
	localparam logic [7:0] REG_MULTSEC = 8'h06;
	localparam logic [7:0] REG_MDMA_SEL = 8'h07;
	localparam logic [7:0] REG_SATA_EN = 8'h08;
	localparam logic [7:0] REG_SERIAL_BASE = 8'h10;
	localparam logic [7:0] REG_MODEL_BASE = 8'h20;
	localparam int unsigned SERIAL_WORDS = 10;
	localparam int unsigned MODEL_WORDS = 20;
	localparam int unsigned STR_WORDS = 30;

	// ----------------------------------------------------------------
	// Page word indices
	// ----------------------------------------------------------------
	localparam logic [7:0] W_CONFIG = 8'h00;
	localparam logic [7:0] W_CYL = 8'h01;
	localparam logic [7:0] W_HEADS = 8'h03;
	localparam logic [7:0] W_SPT = 8'h06;
	localparam logic [7:0] W_TOTAL_LO = 8'h07;
	localparam logic [7:0] W_TOTAL_HI = 8'h08;
	localparam logic [7:0] W_SERIAL_FIRST = 8'h0a;
	localparam logic [7:0] W_SERIAL_LAST = 8'h13;
	localparam logic [7:0] W_MODEL_FIRST = 8'h1b;
	localparam logic [7:0] W_MODEL_LAST = 8'h2e;
	localparam logic [7:0] W_CAP49 = 8'h31;
	localparam logic [7:0] W_CAP50 = 8'h32;
	localparam logic [7:0] W_PIO_LEGACY = 8'h33;
	localparam logic [7:0] W_VALID = 8'h35;
	localparam logic [7:0] W_CUR_CYL = 8'h36;
	localparam logic [7:0] W_CUR_HEADS = 8'h37;
	localparam logic [7:0] W_CUR_SPT = 8'h38;
	localparam logic [7:0] W_CUR_CAP_LO = 8'h39;
	localparam logic [7:0] W_CUR_CAP_HI = 8'h3a;
	localparam logic [7:0] W_MULTSEC = 8'h3b;
	localparam logic [7:0] W_LBA_LO = 8'h3c;
	localparam logic [7:0] W_LBA_HI = 8'h3d;
	localparam logic [7:0] W_MDMA = 8'h3f;
	localparam logic [7:0] W_PIO_ADV = 8'h40;
	localparam logic [7:0] W_MDMA_MIN = 8'h41;
	localparam logic [7:0] W_MDMA_REC = 8'h42;
	localparam logic [7:0] W_PIO_MIN = 8'h43;
	localparam logic [7:0] W_PIO_IORDY = 8'h44;
	localparam logic [7:0] W_FORM = 8'h45;
	localparam logic [7:0] W_QUEUE = 8'h4b;
	localparam logic [7:0] W_SATA_CAP = 8'h4c;
	localparam logic [7:0] W_SATA_SUP = 8'h4e;
	localparam logic [7:0] W_SATA_EN = 8'h4f;
	localparam logic [7:0] W_INTEGRITY = 8'hff;

	// ----------------------------------------------------------------
	// Fixed field values
	// ----------------------------------------------------------------
	localparam logic [15:0] CONFIG_VAL = 16'h045a;
	localparam logic [15:0] CAP49_VAL = 16'h0f00;
	localparam logic [15:0] CAP50_VAL = 16'h0001;
	localparam logic [15:0] PIO_LEGACY_VAL = 16'h0200;
	localparam logic [15:0] VALID_VAL = 16'h0007;
	localparam logic [7:0] MDMA_SUP_VAL = 8'h07;
	localparam logic [15:0] PIO_ADV_VAL = 16'h0003;
	localparam logic [15:0] CYCLE_NS = 16'h0078;
	localparam logic [15:0] FORM_VAL = 16'h8000;
	localparam logic [15:0] MULTSEC_VALID = 16'h0100;
	localparam logic [15:0] SATA_FIELD_MASK = 16'h007e;
	localparam logic [15:0] QUEUE_FIELD_MASK = 16'h001f;
	localparam logic [7:0] SIGNATURE = 8'ha5;
	localparam logic [15:0] PAD_CHARS = 16'h2020;
	localparam logic [1:0] MDMA_NONE = 2'h3;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [15:0] wdata;
	} busReq_t;

	typedef struct packed {
		logic valid;
		logic last;
		logic [7:0] index;
		logic [15:0] data;
	} pageBeat_t;

	typedef struct packed {
		logic busy;
		logic [7:0] idx;
		logic [7:0] sum;
		pageBeat_t beat;
		logic [15:0] rdata;
		logic [31:0] totalSectors;
		logic [15:0] cyl;
		logic [15:0] heads;
		logic [15:0] spt;
		logic multSec;
		logic [1:0] mdmaSel;
		logic [5:0] sataEn;
		logic [STR_WORDS-1:0][15:0] str;
	} state_t;

endpackage : ident_page_pkg

//--- identify_parameter_page.sv
// Identify parameter page generator with its configuration registers
//
// What this block does
// RULE1: Word 0 returns general configuration 045Ah, bit 6 marking non-removable.
// RULE2: Words 7-8 hold total sector count, equal to first invalid block address.
// RULE3: Words 10-19 carry serial number, right justified, padded with 20h bytes.
// RULE4: Words 27-46 carry model number, left justified, padded with 20h bytes.
// RULE5: Word 49: bit 13 zero; bits 11,10,9,8 report ready, disable, LBA, DMA.
// RULE6: Word 50 bit 0 is one: vendor minimum standby timer.
// RULE7: Word 51 upper byte reports legacy PIO mode value 02h.
// RULE8: Word 53 bits 0,1,2 all one: words 54-58, 64-70, 88 valid.
// RULE9: Words 57-58 equal cylinders times heads times sectors per track.
// RULE10: Word 59: bits 15-9 zero, bit 8 one, low byte 00h or 01h.
// RULE11: Word 63 upper byte one-hot selected multiword DMA mode, bits 15-11 zero.
// RULE12: Word 63 lower byte reports supported multiword DMA modes 0 to 2.
// RULE13: Word 64 reports PIO modes 3 and 4 supported, bits 7-2 zero.
// RULE14: Word 65 minimum multiword DMA cycle in ns, not below fastest mode.
// RULE15: Word 66 recommended multiword DMA cycle, not below word 65.
// RULE16: Word 67 PIO cycle without flow control, not below word 68.
// RULE17: Word 68 PIO cycle with flow control, fastest supported PIO mode.
// RULE18: Word 69 bit 15 one: removable card form factor supported.
// RULE19: Word 75 bits 4:0 queue depth minus one, bits 15:5 zero.
// RULE20: Word 76 flags link capabilities; bit 0 zero.
// RULE21: Word 78 bits 6-1 report link features supported; others zero.
// RULE22: Word 79 mirrors word 78 for enabled features; others zero.
// RULE23: Word 255 low byte A5h, upper byte makes the page checksum zero.
// RULE24: Page goes out as 256 consecutive words from 0; undefined words zero.
`timescale 1ns/1ps

module identify_parameter_page import ident_page_pkg::*; #(
	parameter int unsigned QUEUE_DEPTH = 32,
	parameter logic [15:0] SATA_CAP = 16'h0706,
	parameter logic [15:0] SATA_SUPPORT = 16'h0000
) (
	input wire logic clk,
	input wire logic resetn,
	input wire busReq_t busReq,
	output logic [15:0] busRdata,
	input wire logic identifyStart,
	input wire logic pageReady,
	output pageBeat_t pageBeat,
	output logic pageBusy
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] curCapacity(input state_t s);
		logic [47:0] prod;
		prod = 48'(s.cyl) * 48'(s.heads) * 48'(s.spt);
		curCapacity = prod[31:0];
	endfunction : curCapacity

	function automatic logic [7:0] byteSum(input logic [15:0] w);
		byteSum = w[15:8] + w[7:0];
	endfunction : byteSum

	localparam logic [15:0] QUEUE_VAL = 16'(QUEUE_DEPTH - 1) & QUEUE_FIELD_MASK;
	localparam logic [15:0] SATA_SUP_VAL = SATA_SUPPORT & SATA_FIELD_MASK;

	function automatic logic [15:0] pageWord(input state_t s);
		logic [31:0] cap;
		logic [7:0] sel;
		logic [7:0] i;
		i = s.idx;
		cap = curCapacity(s);
		sel = (s.mdmaSel == MDMA_NONE) ? 8'h00 : (8'h01 << s.mdmaSel);
		pageWord = 16'h0000; // RULE24
		if (i >= W_SERIAL_FIRST && i <= W_SERIAL_LAST) begin
			pageWord = s.str[5'(i - W_SERIAL_FIRST)]; // RULE3
		end else if (i >= W_MODEL_FIRST && i <= W_MODEL_LAST) begin
			pageWord = s.str[5'(i - W_MODEL_FIRST + 8'(SERIAL_WORDS))]; // RULE4
		end else begin
			case (i)
				W_CONFIG: pageWord = CONFIG_VAL; // RULE1
				W_CYL, W_CUR_CYL: pageWord = s.cyl;
				W_HEADS, W_CUR_HEADS: pageWord = s.heads;
				W_SPT, W_CUR_SPT: pageWord = s.spt;
				W_TOTAL_LO, W_LBA_LO: pageWord = s.totalSectors[15:0]; // RULE2
				W_TOTAL_HI, W_LBA_HI: pageWord = s.totalSectors[31:16]; // RULE2
				W_CAP49: pageWord = CAP49_VAL; // RULE5
				W_CAP50: pageWord = CAP50_VAL; // RULE6
				W_PIO_LEGACY: pageWord = PIO_LEGACY_VAL; // RULE7
				W_VALID: pageWord = VALID_VAL; // RULE8
				W_CUR_CAP_LO: pageWord = cap[15:0]; // RULE9
				W_CUR_CAP_HI: pageWord = cap[31:16]; // RULE9
				W_MULTSEC: pageWord = MULTSEC_VALID | {15'h0000, s.multSec}; // RULE10
				W_MDMA: pageWord = {sel, MDMA_SUP_VAL}; // RULE11 RULE12
				W_PIO_ADV: pageWord = PIO_ADV_VAL; // RULE13
				W_MDMA_MIN: pageWord = CYCLE_NS; // RULE14
				W_MDMA_REC: pageWord = CYCLE_NS; // RULE15
				W_PIO_MIN: pageWord = CYCLE_NS; // RULE16
				W_PIO_IORDY: pageWord = CYCLE_NS; // RULE17
				W_FORM: pageWord = FORM_VAL; // RULE18
				W_QUEUE: pageWord = QUEUE_VAL; // RULE19
				W_SATA_CAP: pageWord = SATA_CAP & 16'hfffe; // RULE20
				W_SATA_SUP: pageWord = SATA_SUP_VAL; // RULE21
				W_SATA_EN: pageWord = {9'h000, s.sataEn, 1'b0} & SATA_SUP_VAL; // RULE22
				// Upper byte brings the byte sum of all 512 bytes to zero
				W_INTEGRITY: pageWord = {8'h00 - (s.sum + SIGNATURE), SIGNATURE}; // RULE23
				default: pageWord = 16'h0000;
			endcase
		end
	endfunction : pageWord

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	state_t st_ff;
	state_t nxt_st;

	always_comb begin
		logic [15:0] word;
		logic load;
		logic [7:0] a;
		word = 16'h0000;
		load = 1'b0;
		a = busReq.addr;
		nxt_st = st_ff;

		// Beat leaves when the host takes it; refill in the same cycle
		if (st_ff.beat.valid && pageReady) begin
			nxt_st.beat.valid = 1'b0;
		end
		if (st_ff.busy && (!st_ff.beat.valid || pageReady)) begin
			load = 1'b1;
		end
		if (load) begin
			word = pageWord(st_ff);
			nxt_st.beat.valid = 1'b1;
			nxt_st.beat.index = st_ff.idx;
			nxt_st.beat.data = word;
			nxt_st.beat.last = (st_ff.idx == W_INTEGRITY);
			nxt_st.sum = st_ff.sum + byteSum(word);
			nxt_st.idx = st_ff.idx + 8'h01; // RULE24
			if (st_ff.idx == W_INTEGRITY) begin
				nxt_st.busy = 1'b0;
			end
		end
		// A start while a page is in flight is ignored
		if (identifyStart && !st_ff.busy) begin
			nxt_st.busy = 1'b1;
			nxt_st.idx = W_CONFIG; // RULE24
			nxt_st.sum = 8'h00;
		end

		// Register writes
		if (busReq.wr) begin
			if (a >= REG_SERIAL_BASE && a < REG_SERIAL_BASE + 8'(SERIAL_WORDS)) begin
				nxt_st.str[5'(a - REG_SERIAL_BASE)] = busReq.wdata; // RULE3
			end else if (a >= REG_MODEL_BASE && a < REG_MODEL_BASE + 8'(MODEL_WORDS)) begin
				nxt_st.str[5'(a - REG_MODEL_BASE + 8'(SERIAL_WORDS))] = busReq.wdata; // RULE4
			end else begin
				case (a)
					REG_TOTAL_LO: nxt_st.totalSectors[15:0] = busReq.wdata;
					REG_TOTAL_HI: nxt_st.totalSectors[31:16] = busReq.wdata;
					REG_CYL: nxt_st.cyl = busReq.wdata;
					REG_HEADS: nxt_st.heads = busReq.wdata;
					REG_SPT: nxt_st.spt = busReq.wdata;
					REG_MULTSEC: nxt_st.multSec = busReq.wdata[0]; // RULE10
					REG_MDMA_SEL: nxt_st.mdmaSel = busReq.wdata[1:0]; // RULE11
					REG_SATA_EN: nxt_st.sataEn = busReq.wdata[6:1]; // RULE22
					default: ;
				endcase
			end
		end

		// Register reads; unmapped addresses read zero
		nxt_st.rdata = 16'h0000;
		if (busReq.rd) begin
			if (a >= REG_SERIAL_BASE && a < REG_SERIAL_BASE + 8'(SERIAL_WORDS)) begin
				nxt_st.rdata = st_ff.str[5'(a - REG_SERIAL_BASE)];
			end else if (a >= REG_MODEL_BASE && a < REG_MODEL_BASE + 8'(MODEL_WORDS)) begin
				nxt_st.rdata = st_ff.str[5'(a - REG_MODEL_BASE + 8'(SERIAL_WORDS))];
			end else begin
				case (a)
					REG_STATUS: nxt_st.rdata = {7'h00, st_ff.busy, st_ff.idx};
					REG_TOTAL_LO: nxt_st.rdata = st_ff.totalSectors[15:0];
					REG_TOTAL_HI: nxt_st.rdata = st_ff.totalSectors[31:16];
					REG_CYL: nxt_st.rdata = st_ff.cyl;
					REG_HEADS: nxt_st.rdata = st_ff.heads;
					REG_SPT: nxt_st.rdata = st_ff.spt;
					REG_MULTSEC: nxt_st.rdata = {15'h0000, st_ff.multSec};
					REG_MDMA_SEL: nxt_st.rdata = {14'h0000, st_ff.mdmaSel};
					REG_SATA_EN: nxt_st.rdata = {9'h000, st_ff.sataEn, 1'b0};
					default: nxt_st.rdata = 16'h0000;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_ff <= '0;
			st_ff.str <= {STR_WORDS{PAD_CHARS}}; // RULE3 RULE4
			st_ff.mdmaSel <= MDMA_NONE;
			st_ff.multSec <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign busRdata = st_ff.rdata;
	assign pageBeat = st_ff.beat;
	assign pageBusy = st_ff.busy;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [7:0] chkSum_ff;
	logic [15:0] mdmaMin_ff;
	logic [15:0] pioMin_ff;
	logic [15:0] sataSup_ff;
	logic [31:0] chkCap;

	assign chkCap = curCapacity(st_ff);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			chkSum_ff <= 8'h00;
			mdmaMin_ff <= 16'h0000;
			pioMin_ff <= 16'h0000;
			sataSup_ff <= 16'h0000;
		end else if (pageBeat.valid && pageReady) begin
			chkSum_ff <= (pageBeat.last) ? 8'h00 : chkSum_ff + byteSum(pageBeat.data);
			if (pageBeat.index == W_MDMA_MIN) mdmaMin_ff <= pageBeat.data;
			if (pageBeat.index == W_PIO_MIN) pioMin_ff <= pageBeat.data;
			if (pageBeat.index == W_SATA_SUP) sataSup_ff <= pageBeat.data;
		end
	end

	a_word0_value: assert property (@(posedge clk) disable iff (!resetn) // RULE1
		pageBeat.valid && pageBeat.index == W_CONFIG |-> pageBeat.data == 16'h045a && pageBeat.data[6])
		else $error("word 0 wrong");

	a_total_sectors: assert property (@(posedge clk) disable iff (!resetn) // RULE2
		pageBeat.valid && pageBeat.index == W_TOTAL_HI |-> pageBeat.data == st_ff.totalSectors[31:16])
		else $error("total sectors high word wrong");

	a_total_low: assert property (@(posedge clk) disable iff (!resetn) // RULE2
		pageBeat.valid && pageBeat.index == W_TOTAL_LO
		|-> pageBeat.data == st_ff.totalSectors[15:0])
		else $error("total sectors low word wrong");

	a_string_fields: assert property (@(posedge clk) disable iff (!resetn) // RULE3
		pageBeat.valid && pageBeat.index >= W_SERIAL_FIRST && pageBeat.index <= W_SERIAL_LAST
		|-> pageBeat.data == st_ff.str[5'(pageBeat.index - W_SERIAL_FIRST)])
		else $error("string field wrong");

	a_serial_first: assert property (@(posedge clk) disable iff (!resetn) // RULE3
		pageBeat.valid && pageBeat.index == W_SERIAL_FIRST |-> pageBeat.data == st_ff.str[0])
		else $error("serial word wrong");

	a_model_last: assert property (@(posedge clk) disable iff (!resetn) // RULE4
		pageBeat.valid && pageBeat.index == W_MODEL_LAST |-> pageBeat.data == st_ff.str[STR_WORDS-1])
		else $error("model word wrong");

	a_model_words: assert property (@(posedge clk) disable iff (!resetn) // RULE4
		pageBeat.valid && pageBeat.index >= W_MODEL_FIRST && pageBeat.index <= W_MODEL_LAST
		|-> pageBeat.data == st_ff.str[5'(pageBeat.index - W_MODEL_FIRST + 8'(SERIAL_WORDS))])
		else $error("model string word wrong");

	a_cap_flags: assert property (@(posedge clk) disable iff (!resetn) // RULE5
		pageBeat.valid && pageBeat.index == W_CAP49 |-> !pageBeat.data[13] && pageBeat.data[11:8] == 4'hf)
		else $error("word 49 wrong");

	a_standby_min: assert property (@(posedge clk) disable iff (!resetn) // RULE6
		pageBeat.valid && pageBeat.index == W_CAP50 |-> pageBeat.data[0])
		else $error("word 50 bit 0 clear");

	a_pio_legacy: assert property (@(posedge clk) disable iff (!resetn) // RULE7
		pageBeat.valid && pageBeat.index == W_PIO_LEGACY |-> pageBeat.data[15:8] == 8'h02)
		else $error("word 51 wrong");

	a_validity_flags: assert property (@(posedge clk) disable iff (!resetn) // RULE8
		pageBeat.valid && pageBeat.index == W_VALID |-> pageBeat.data[2:0] == 3'h7)
		else $error("word 53 flags wrong");

	a_cur_capacity: assert property (@(posedge clk) disable iff (!resetn) // RULE9
		pageBeat.valid && pageBeat.index == W_CUR_CAP_LO |-> pageBeat.data == chkCap[15:0])
		else $error("current capacity wrong");

	a_cap_high: assert property (@(posedge clk) disable iff (!resetn) // RULE9
		pageBeat.valid && pageBeat.index == W_CUR_CAP_HI
		|-> pageBeat.data == chkCap[31:16])
		else $error("current capacity high word wrong");

	a_cur_geometry: assert property (@(posedge clk) disable iff (!resetn) // RULE9
		pageBeat.valid && pageBeat.index == W_CUR_SPT
		|-> pageBeat.data == st_ff.spt)
		else $error("current sectors per track wrong");

	a_multsec_word: assert property (@(posedge clk) disable iff (!resetn) // RULE10
		pageBeat.valid && pageBeat.index == W_MULTSEC |-> pageBeat.data[15:8] == 8'h01 && pageBeat.data[7:1] == 7'h00)
		else $error("word 59 wrong");

	a_mdma_word: assert property (@(posedge clk) disable iff (!resetn) // RULE11
		pageBeat.valid && pageBeat.index == W_MDMA |-> $onehot0(pageBeat.data[15:8]) && pageBeat.data[15:11] == 5'h00 && pageBeat.data[7:3] == 5'h00)
		else $error("word 63 wrong");

	a_mdma_support: assert property (@(posedge clk) disable iff (!resetn) // RULE12
		pageBeat.valid && pageBeat.index == W_MDMA
		|-> pageBeat.data[7:0] == 8'h07)
		else $error("word 63 support field wrong");

	a_pio_adv: assert property (@(posedge clk) disable iff (!resetn) // RULE13
		pageBeat.valid && pageBeat.index == W_PIO_ADV |-> pageBeat.data == 16'h0003)
		else $error("word 64 wrong");

	a_mdma_min: assert property (@(posedge clk) disable iff (!resetn) // RULE14
		pageBeat.valid && pageBeat.index == W_MDMA_MIN
		|-> pageBeat.data != 16'h0000)
		else $error("word 65 zero");

	a_mdma_order: assert property (@(posedge clk) disable iff (!resetn) // RULE15
		pageBeat.valid && pageBeat.index == W_MDMA_REC |-> pageBeat.data >= mdmaMin_ff)
		else $error("word 66 below word 65");

	a_pio_order: assert property (@(posedge clk) disable iff (!resetn) // RULE16
		pageBeat.valid && pageBeat.index == W_PIO_IORDY
		|-> pageBeat.data <= pioMin_ff && pioMin_ff != 16'h0000)
		else $error("word 67 below word 68");

	a_pio_iordy: assert property (@(posedge clk) disable iff (!resetn) // RULE17
		pageBeat.valid && pageBeat.index == W_PIO_IORDY
		|-> pageBeat.data == CYCLE_NS)
		else $error("word 68 wrong");

	a_form_factor: assert property (@(posedge clk) disable iff (!resetn) // RULE18
		pageBeat.valid && pageBeat.index == W_FORM |-> pageBeat.data[15])
		else $error("word 69 bit 15 clear");

	a_queue_depth: assert property (@(posedge clk) disable iff (!resetn) // RULE19
		pageBeat.valid && pageBeat.index == W_QUEUE |-> pageBeat.data == 16'(QUEUE_DEPTH - 1))
		else $error("queue depth wrong");

	a_link_cap: assert property (@(posedge clk) disable iff (!resetn) // RULE20
		pageBeat.valid && pageBeat.index == W_SATA_CAP |-> !pageBeat.data[0])
		else $error("word 76 bit 0 set");

	a_link_support: assert property (@(posedge clk) disable iff (!resetn) // RULE21
		pageBeat.valid && pageBeat.index == W_SATA_SUP
		|-> pageBeat.data[15:7] == 9'h000 && !pageBeat.data[0])
		else $error("word 78 reserved bits set");

	a_link_enabled: assert property (@(posedge clk) disable iff (!resetn) // RULE22
		pageBeat.valid && pageBeat.index == W_SATA_EN |-> (pageBeat.data & ~sataSup_ff) == 16'h0000)
		else $error("word 79 beyond word 78");

	a_integrity_sum: assert property (@(posedge clk) disable iff (!resetn) // RULE23
		pageBeat.valid && pageBeat.last |-> pageBeat.data[7:0] == 8'ha5 && 8'(chkSum_ff + byteSum(pageBeat.data)) == 8'h00)
		else $error("integrity word wrong");

	a_index_step: assert property (@(posedge clk) disable iff (!resetn) // RULE24
		pageBeat.valid && pageReady && !pageBeat.last |=> pageBeat.valid && pageBeat.index == $past(pageBeat.index) + 8'h01)
		else $error("page words not consecutive");

	a_start_first: assert property (@(posedge clk) disable iff (!resetn) // RULE24
		identifyStart && !pageBusy && !pageBeat.valid |=> ##1 pageBeat.valid && pageBeat.index == 8'h00)
		else $error("page does not start at word 0");

	// ----------------------------------------------------------------
	// Stream checks
	// ----------------------------------------------------------------
	a_reserved_zero: assert property (@(posedge clk) disable iff (!resetn) // RULE24
		pageBeat.valid && pageBeat.index > W_SATA_EN && pageBeat.index < W_INTEGRITY
		|-> pageBeat.data == 16'h0000)
		else $error("reserved word not zero");

	a_last_flag: assert property (@(posedge clk) disable iff (!resetn) // RULE24
		pageBeat.valid
		|-> pageBeat.last == (pageBeat.index == W_INTEGRITY))
		else $error("last flag misplaced");

	// A stalled beat must not change under the host
	a_beat_hold: assert property (@(posedge clk) disable iff (!resetn) // RULE24
		pageBeat.valid && !pageReady
		|=> pageBeat.valid && $stable(pageBeat.index) && $stable(pageBeat.data))
		else $error("stalled beat changed");

endmodule : identify_parameter_page

//--- page_sink.sv
// Host-side reader model that accepts identify page beats and records them
`timescale 1ns/1ps

module page_sink import ident_page_pkg::*; (
	input wire logic clk,
	input wire logic resetn,
	input wire logic slow,
	input wire pageBeat_t pageBeat,
	output logic pageReady,
	output logic [15:0] page [256],
	output int taken,
	output int badOrder
);
	logic [1:0] cyc;

	// ----------------------------------------------------------------
	// Acceptance and order tracking
	// ----------------------------------------------------------------
	// Slow mode stalls three cycles of four so every beat must be held
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pageReady <= 1'b0;
			cyc <= 2'h0;
			taken <= 0;
			badOrder <= 0;
		end else begin
			cyc <= cyc + 2'h1;
			pageReady <= !slow || cyc == 2'h0;
			if (pageBeat.valid && pageReady) begin
				page[pageBeat.index] <= pageBeat.data;
				taken <= taken + 1;
				if (pageBeat.index !== taken[7:0] || pageBeat.last !== (pageBeat.index == 8'hff)) begin
					badOrder <= badOrder + 1;
				end
			end
		end
	end
endmodule : page_sink

//--- tb.sv
// Self-checking bench for the identify parameter page generator
`timescale 1ns/1ps

module tb import ident_page_pkg::*;;
	localparam logic [15:0] SUP = 16'h00db;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	busReq_t busReq = '0;
	logic [15:0] busRdata;
	logic identifyStart = 1'b0;
	logic pageReady;
	pageBeat_t pageBeat;
	logic pageBusy;
	logic slow = 1'b0;
	logic [15:0] got [256];
	int taken;
	int badOrder;
	int failures = 0;
	int check_count = 0;
	int cycles = 0;
	integer seed = 32'h207c;
	logic [31:0] total = '0;
	logic [15:0] cyl = '0, heads = '0, spt = '0;
	logic multSec = 1'b1;
	logic [1:0] mdma = 2'h3;
	logic [5:0] sataEn = '0;
	logic [15:0] str [30];

	identify_parameter_page #(.QUEUE_DEPTH(32), .SATA_CAP(16'h0706), .SATA_SUPPORT(SUP))
	i_identify_parameter_page (.clk(clk), .resetn(resetn), .busReq(busReq), .busRdata(busRdata),
		.identifyStart(identifyStart), .pageReady(pageReady), .pageBeat(pageBeat),
		.pageBusy(pageBusy));
	page_sink i_page_sink (.clk(clk), .resetn(resetn), .slow(slow), .pageBeat(pageBeat),
		.pageReady(pageReady), .page(got), .taken(taken), .badOrder(badOrder));

	always #12.5 clk = ~clk;

	// ----------------------------------------------------------------
	// Checking and closing
	// ----------------------------------------------------------------
	task automatic summarize();
		$display("failures=%0d checks=%0d", failures, check_count);
		if (failures == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize

	task automatic chk(input logic [15:0] g, input logic [15:0] e, input int n);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("unexpected at %0t: item %0d got %h expected %h", $time, n, g, e);
		end
	endtask : chk

	// Budget covers five pages, two of them stalled
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			$display("unexpected at %0t: run did not finish", $time);
			summarize();
		end
	end

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	task automatic busWr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		busReq <= '0;
	endtask : busWr

	task automatic busRd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge clk);
		busReq <= '0;
		#1 chk(busRdata, e, a);
		@(posedge clk);
		#1 chk(busRdata, 16'h0000, a);
	endtask : busRd

	// ----------------------------------------------------------------
	// Expected page
	// ----------------------------------------------------------------
	function automatic logic [15:0] expWord(input int i);
		logic [31:0] cap;
		cap = cyl * heads * spt;
		case (i)
			0: return 16'h045a;
			1, 54: return cyl;
			3, 55: return heads;
			6, 56: return spt;
			7, 60: return total[15:0];
			8, 61: return total[31:16];
			49: return CAP49_VAL;
			50: return 16'h0001;
			51: return 16'h0200;
			53: return 16'h0007;
			57: return cap[15:0];
			58: return cap[31:16];
			59: return {15'h0080, multSec};
			63: return {5'h00, (mdma == 2'h3) ? 3'h0 : 3'h1 << mdma, 8'h07};
			64: return 16'h0003;
			65, 66, 67, 68: return CYCLE_NS;
			69: return 16'h8000;
			75: return 16'h001f;
			76: return 16'h0706;
			78: return SUP & 16'h007e;
			79: return {9'h000, sataEn, 1'b0} & SUP & 16'h007e;
			default: begin
				if (i >= 10 && i <= 19) return str[i - 10];
				if (i >= 27 && i <= 46) return str[i - 17];
				return 16'h0000;
			end
		endcase
	endfunction : expWord

	task automatic runPage(input logic s);
		int base;
		int k;
		logic [7:0] sum;
		base = taken;
		slow <= s;
		@(posedge clk);
		identifyStart <= 1'b1;
		@(posedge clk);
		identifyStart <= 1'b0;
		#1 chk(pageBusy, 16'h0001, 900);
		@(posedge clk);
		identifyStart <= 1'b1;
		@(posedge clk);
		identifyStart <= 1'b0;
		for (k = 0; k < 3000 && taken < base + 256; k++) @(posedge clk);
		repeat (6) @(posedge clk);
		#1 chk(taken - base, 16'd256, 901);
		chk(pageBusy, 16'h0000, 902);
		chk(badOrder, 16'h0000, 903);
		sum = 8'h00;
		for (k = 0; k < 255; k++) chk(got[k], expWord(k), k);
		for (k = 0; k < 256; k++) sum = sum + got[k][15:8] + got[k][7:0];
		chk(got[255][7:0], 16'h00a5, 255);
		chk(sum, 16'h0000, 904);
	endtask : runPage

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		int k;
		int j;
		for (k = 0; k < 30; k++) str[k] = 16'h2020;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		busRd(REG_STATUS, 16'h0000);
		busRd(8'h09, 16'h0000);
		busRd(8'hc5, 16'h0000);
		runPage(1'b0);
		for (k = 0; k < 4; k++) begin
			total = $random(seed);
			cyl = $random(seed) & 16'h03ff;
			heads = $random(seed) & 16'h03ff;
			spt = $random(seed) & 16'h03ff;
			multSec = k[0];
			mdma = k[1:0];
			sataEn = $random(seed);
			busWr(REG_TOTAL_LO, total[15:0]);
			busWr(REG_TOTAL_HI, total[31:16]);
			busWr(REG_CYL, cyl);
			busWr(REG_HEADS, heads);
			busWr(REG_SPT, spt);
			busWr(REG_MULTSEC, {15'h0000, multSec});
			busWr(REG_MDMA_SEL, {14'h0000, mdma});
			busWr(REG_SATA_EN, {9'h000, sataEn, 1'b0});
			busWr(8'h0c, 16'hdead);
			for (j = 0; j < 3; j++) begin
				int w;
				w = {$random(seed)} % 30;
				str[w] = $random(seed);
				busWr((w < 10) ? 8'h10 + w[7:0] : 8'h16 + w[7:0], str[w]);
			end
			busRd(REG_TOTAL_HI, total[31:16]);
			busRd(REG_TOTAL_LO, total[15:0]);
			busRd(REG_SPT, spt);
			busRd(REG_MULTSEC, {15'h0000, multSec});
			busRd(REG_MDMA_SEL, {14'h0000, mdma});
			busRd(REG_SATA_EN, {9'h000, sataEn, 1'b0});
			runPage(k[0]);
		end
		summarize();
	end
endmodule : tb
